/* rtl/dtpt_pkg.sv */
// constants and types for the down timer with pwm and tone
package dtpt_pkg;
   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_CNT_LOW = 5'h00;
   localparam logic [4:0] IDX_CTRL_ONE = 5'h01;
   localparam logic [4:0] IDX_CTRL_TWO = 5'h02;
   localparam logic [4:0] IDX_PWM_A_DUTY = 5'h03;
   localparam logic [4:0] IDX_PRESCALE = 5'h04;
   localparam logic [4:0] IDX_TONE = 5'h05;
   localparam logic [4:0] IDX_PWM_B_CTRL = 5'h0a;
   localparam logic [4:0] IDX_PWM_B_DUTY = 5'h0c;
   localparam logic [4:0] IDX_TIMER_HIGH = 5'h10;
   localparam logic [4:0] IDX_STATUS = 5'h11;
   ////////////////////////////////////////////////////////////////////////
   // control one fields
   localparam int B_RUN = 0;
   localparam int B_RELOAD = 1;
   localparam int B_SINGLE = 2;
   localparam int B_A_LOW = 6;
   localparam int B_A_DRIVE = 7;
   // control two fields
   localparam int B_PS_LSB = 0;
   localparam int B_PS_OFF = 3;
   localparam int B_EDGE = 4;
   localparam int B_SRC = 5;
   // pwm b control fields
   localparam int B_FAST = 3;
   localparam int B_B_LOW = 6;
   localparam int B_B_DRIVE = 7;
   // tone fields
   localparam int B_TONE_DRIVE = 7;
   // timer high fields
   localparam int B_TH_RELOAD = 4;
   localparam int B_TH_B_DUTY = 2;
   localparam int B_TH_A_DUTY = 0;
   // status fields
   localparam int B_UFL = 0;
   localparam int B_IRQ_EN = 1;
   localparam int B_GATE = 2;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [5:0] CTRL_TWO_RST = 6'h3f;
   localparam logic [7:0] PWM_B_CTRL_RST = 8'h00;
   localparam logic [7:0] TONE_RST = 8'h0f;
   localparam logic [7:0] PRESCALE_RST = 8'hff;
   localparam logic [9:0] CNT_ALL_ONES = 10'h3ff;
   localparam int INST_DIV = 4;
   localparam int FAST_DIV = 1;

   typedef struct packed {
      logic level;
      logic drive;
   } dtpt_pin_t;
endpackage : dtpt_pkg

/* rtl/dtpt_pwm_chan.sv */
// one pwm channel: duty compare against the shared down counter
`timescale 1ns/1ns
`default_nettype none
module dtpt_pwm_chan
   import dtpt_pkg::*;
#(
   parameter int W = 10
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // compare inputs
   input wire logic [W-1:0] count_i,
   input wire logic [W-1:0] duty_i,
   input wire logic low_active_i,
   input wire logic pin_drive_i,
   // pin
   output var dtpt_pin_t pin_o
);
   logic active;

   assign active = count_i < duty_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= '0;
      end else begin
         pin_o.level <= active ^ low_active_i;
         pin_o.drive <= pin_drive_i;
      end
   end
endmodule : dtpt_pwm_chan
`default_nettype wire

/* rtl/dtpt_timer.sv */
// down timer with prescaler, two pwm channels and tone, wishbone slave
`timescale 1ns/1ns
`default_nettype none
module dtpt_timer
   import dtpt_pkg::*;
#(
   parameter int CW = 10,
   parameter int INST_RATE = INST_DIV,
   parameter int FAST_RATE = FAST_DIV
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [6:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins
   input wire logic ext_count_pin_i,
   output var dtpt_pin_t port_pin_2_o,
   output var dtpt_pin_t port_pin_0_o,
   output logic tone_out_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_one_reg;
   logic [5:0] ctrl_two_reg;
   logic [7:0] pwm_b_ctrl_reg;
   logic [7:0] tone_reg;
   logic [7:0] duty_a_reg;
   logic [7:0] duty_b_reg;
   logic [5:0] timer_high_reg;
   logic [CW-1:0] reload_reg;
   logic [CW-1:0] down_counter_reg;
   logic [7:0] prescale_value;
   logic underflow_flag;
   logic irq_en_reg;
   logic global_irq_gate;
   logic [7:0] inst_div_reg;
   logic [7:0] fast_div_reg;
   logic ext_prev_reg;
   logic tone_reg_out;
   logic tone_prev_reg;

   logic req;
   logic wr;
   logic [4:0] idx;
   logic inst_tick;
   logic fast_tick;
   logic ext_tick;
   logic src_tick;
   logic ps_pulse;
   logic step;
   logic underflow;
   logic [7:0] ps_next;
   logic [7:0] ps_mask;
   logic [2:0] prescale_ratio;
   logic prescale_off;
   logic counter_run;
   logic tone_level;
   logic [3:0] tone_rate_select;
   logic [31:0] rd_data;
   dtpt_pin_t pwm_a;
   dtpt_pin_t pwm_b;

   assign req = cyc_i & stb_i & ~ack_o;
   // a write lands at the edge where the master sees ack, not before
   assign wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
   assign idx = adr_i[6:2];
   assign prescale_ratio = ctrl_two_reg[B_PS_LSB +: 3];
   assign prescale_off = ctrl_two_reg[B_PS_OFF];
   assign counter_run = ctrl_one_reg[B_RUN];
   assign tone_rate_select = tone_reg[3:0];

   ////////////////////////////////////////////////////////////////////////
   // count sources; all slower rates are enables off the one clock
   assign inst_tick = inst_div_reg == 8'(INST_RATE - 1);
   assign fast_tick = fast_div_reg == 8'(FAST_RATE - 1);
   assign ext_tick = ctrl_two_reg[B_EDGE] ?
      (ext_prev_reg & ~ext_count_pin_i) :
      (~ext_prev_reg & ext_count_pin_i);

   always_comb begin
      if (pwm_b_ctrl_reg[B_FAST]) begin
         src_tick = fast_tick;
      end else if (ctrl_two_reg[B_SRC]) begin
         src_tick = ext_tick;
      end else begin
         src_tick = inst_tick;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inst_div_reg <= 8'h00;
         fast_div_reg <= 8'h00;
         ext_prev_reg <= 1'b0;
      end else begin
         inst_div_reg <= inst_tick ? 8'h00 : inst_div_reg + 8'h01;
         fast_div_reg <= fast_tick ? 8'h00 : fast_div_reg + 8'h01;
         ext_prev_reg <= ext_count_pin_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // prescaler: free counter, pulse when the low ratio+1 bits wrap
   assign ps_next = prescale_value + 8'h01;
   assign ps_mask = 8'((9'h002 << prescale_ratio) - 9'h001);
   assign ps_pulse = src_tick & ((ps_next & ps_mask) == 8'h00);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescale_value <= PRESCALE_RST;
      end else if (src_tick) begin
         prescale_value <= ps_next;
      end
   end

   // is software's: a ratio change mid-count may give an early pulse
   assign step = counter_run & (prescale_off ? src_tick : ps_pulse);
   assign underflow = step & (down_counter_reg == '0);

   ////////////////////////////////////////////////////////////////////////
   // down counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         down_counter_reg <= '0;
      end else if (wr && idx == IDX_CNT_LOW) begin
         down_counter_reg <= {timer_high_reg[B_TH_RELOAD +: 2], dat_i[7:0]};
      end else if (underflow) begin
         if (ctrl_one_reg[B_SINGLE]) begin
            down_counter_reg <= '0;
         end else if (ctrl_one_reg[B_RELOAD]) begin
            down_counter_reg <= reload_reg;
         end else begin
            down_counter_reg <= CNT_ALL_ONES;
         end
      end else if (step) begin
         down_counter_reg <= down_counter_reg - CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_reg <= '0;
      end else if (wr && idx == IDX_CNT_LOW) begin
         reload_reg <= {timer_high_reg[B_TH_RELOAD +: 2], dat_i[7:0]};
      end else if (wr && idx == IDX_TIMER_HIGH) begin
         reload_reg[9:8] <= dat_i[B_TH_RELOAD +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_one_reg <= CTRL_ONE_RST;
      end else if (wr && idx == IDX_CTRL_ONE) begin
         ctrl_one_reg <= dat_i[7:0] & 8'hc7;
      end else if (underflow && ctrl_one_reg[B_SINGLE]) begin
         ctrl_one_reg[B_RUN] <= 1'b0;
      end
   end

   // count source and prescaler setup
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_two_reg <= CTRL_TWO_RST;
         pwm_b_ctrl_reg <= PWM_B_CTRL_RST;
      end else if (wr) begin
         case (idx)
            IDX_CTRL_TWO: ctrl_two_reg <= dat_i[5:0];
            IDX_PWM_B_CTRL: pwm_b_ctrl_reg <= dat_i[7:0] & 8'hc8;
            default: ;
         endcase
      end
   end

   // tone setup; write-only, so reserved bits are dropped here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_reg <= TONE_RST;
      end else if (wr && idx == IDX_TONE) begin
         tone_reg <= dat_i[7:0] & 8'h8f;
      end
   end

   // pwm duties and the high bits they share with the reload value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duty_a_reg <= 8'h00;
         duty_b_reg <= 8'h00;
         timer_high_reg <= 6'h00;
      end else if (wr) begin
         case (idx)
            IDX_PWM_A_DUTY: duty_a_reg <= dat_i[7:0];
            IDX_PWM_B_DUTY: duty_b_reg <= dat_i[7:0];
            IDX_TIMER_HIGH: timer_high_reg <= dat_i[5:0];
            default: ;
         endcase
      end
   end

   // sticky flag: hardware set wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         underflow_flag <= 1'b0;
         irq_en_reg <= 1'b0;
         global_irq_gate <= 1'b0;
      end else begin
         if (underflow) begin
            underflow_flag <= 1'b1;
         end else if (wr && idx == IDX_STATUS && dat_i[B_UFL]) begin
            underflow_flag <= 1'b0;
         end
         if (wr && idx == IDX_STATUS) begin
            irq_en_reg <= dat_i[B_IRQ_EN];
            global_irq_gate <= dat_i[B_GATE];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= underflow_flag & irq_en_reg & global_irq_gate;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm channels share the down counter as frame, the reload value only when reload is set; counter sets phase
   dtpt_pwm_chan #(.W(CW)) u_pwm_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .count_i(down_counter_reg),
      .duty_i({timer_high_reg[B_TH_A_DUTY +: 2], duty_a_reg}),
      .low_active_i(ctrl_one_reg[B_A_LOW]),
      .pin_drive_i(ctrl_one_reg[B_A_DRIVE]),
      .pin_o(pwm_a)
   );

   dtpt_pwm_chan #(.W(CW)) u_pwm_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .count_i(down_counter_reg),
      .duty_i({timer_high_reg[B_TH_B_DUTY +: 2], duty_b_reg}),
      .low_active_i(pwm_b_ctrl_reg[B_B_LOW]),
      .pin_drive_i(pwm_b_ctrl_reg[B_B_DRIVE]),
      .pin_o(pwm_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // tone: prescaler or down counter bit k halves per step, giving 1:2 .. 1:256
   always_comb begin
      if (tone_rate_select[3]) begin
         tone_level = down_counter_reg[tone_rate_select[2:0]];
      end else begin
         tone_level = prescale_value[tone_rate_select[2:0]];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_reg_out <= 1'b0;
         tone_prev_reg <= 1'b0;
      end else begin
         tone_reg_out <= tone_reg[B_TONE_DRIVE] & tone_level;
         tone_prev_reg <= tone_reg[B_TONE_DRIVE];
      end
   end

   // pin 2 is shared; tone takes it over pwm a when both are on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_pin_2_o <= '0;
         port_pin_0_o <= '0;
         tone_out_o <= 1'b0;
      end else begin
         tone_out_o <= tone_reg_out;
         if (tone_prev_reg) begin
            port_pin_2_o <= '{level: tone_reg_out, drive: 1'b1};
         end else begin
            port_pin_2_o <= pwm_a;
         end
         port_pin_0_o <= pwm_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wishbone read mux; write-only and unmapped words read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (idx)
         IDX_CNT_LOW: rd_data[7:0] = down_counter_reg[7:0];
         IDX_CTRL_ONE: rd_data[2:0] = ctrl_one_reg[2:0];
         IDX_CTRL_TWO: rd_data[5:0] = ctrl_two_reg;
         IDX_PRESCALE: rd_data[7:0] = prescale_value;
         IDX_TIMER_HIGH: rd_data[5:0] =
            {down_counter_reg[9:8], timer_high_reg[3:0]};
         IDX_STATUS: rd_data[2:0] =
            {global_irq_gate, irq_en_reg, underflow_flag};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         dat_o <= req ? rd_data : 32'h0000_0000;
      end
   end
endmodule : dtpt_timer
`default_nettype wire

/* tb/dtpt_ext_src.sv */
// behavioural source for the external count pin
`timescale 1ns/1ns
`default_nettype none
module dtpt_ext_src (
   // clock
   input wire logic clk_i,
   // count pin
   output logic pin_o
);
   initial pin_o = 1'b0;
   // level held four clocks so the sampler sees every edge
   task automatic edge_to(input logic v);
      @(posedge clk_i);
      pin_o <= v;
      repeat (4) @(posedge clk_i);
   endtask : edge_to
endmodule : dtpt_ext_src
`default_nettype wire

/* tb/dtpt_timer_chk.sv */
// port assertions for the down timer
`timescale 1ns/1ns
`default_nettype none
module dtpt_timer_chk
   import dtpt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [6:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // pins
   input wire dtpt_pin_t port_pin_2_o,
   input wire dtpt_pin_t port_pin_0_o,
   input wire logic tone_out_o,
   input wire logic irq_o
);
   logic [4:0] idx_reg;
   logic rd_reg;
   // irq en, gate, a drive, b drive, tone drive
   logic [4:0] cfg_reg;
   logic pin2_off;
   assign pin2_off = ~cfg_reg[2] & ~cfg_reg[4];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idx_reg <= 5'h00;
         rd_reg <= 1'b0;
      end else if (cyc_i & stb_i & ~ack_o) begin
         idx_reg <= adr_i[6:2];
         rd_reg <= ~we_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= 5'h00;
      end else if (cyc_i & stb_i & ack_o & we_i & sel_i[0]) begin
         case (adr_i[6:2])
            IDX_STATUS: cfg_reg[1:0] <= dat_i[2:1];
            IDX_CTRL_ONE: cfg_reg[2] <= dat_i[7];
            IDX_PWM_B_CTRL: cfg_reg[3] <= dat_i[7];
            IDX_TONE: cfg_reg[4] <= dat_i[7];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_irq_gate:
      assert property (!cfg_reg[1] && !$past(cfg_reg[1]) |-> !irq_o)
      else $error("irq with gate closed");
   a_irq_enable:
      assert property (!cfg_reg[0] && !$past(cfg_reg[0]) |-> !irq_o)
      else $error("irq while masked");
   a_tone_off:
      assert property (!cfg_reg[4] && !$past(cfg_reg[4])
         && !$past(cfg_reg[4], 2) |-> !tone_out_o)
      else $error("tone while disabled");
   a_pin2_pwm:
      assert property (cfg_reg[2] && $past(cfg_reg[2]) && $past(cfg_reg[2], 2)
         |-> port_pin_2_o.drive)
      else $error("pin 2 not driven");
   a_pin2_idle:
      assert property (pin2_off && $past(pin2_off) && $past(pin2_off, 2)
         |-> !port_pin_2_o.drive)
      else $error("pin 2 driven while off");
   a_pin0_drive:
      assert property (cfg_reg[3] == $past(cfg_reg[3])
         ##1 cfg_reg[3] == $past(cfg_reg[3]) |-> port_pin_0_o.drive == cfg_reg[3])
      else $error("pin 0 drive wrong");
   a_duty_read:
      assert property (ack_o && rd_reg && idx_reg == IDX_PWM_A_DUTY
         |-> dat_o == 32'h0)
      else $error("duty read not zero");
   a_read_width:
      assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule : dtpt_timer_chk
bind dtpt_timer dtpt_timer_chk dtpt_timer_chk_i (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .port_pin_2_o(port_pin_2_o),
   .port_pin_0_o(port_pin_0_o), .tone_out_o(tone_out_o), .irq_o(irq_o));
`default_nettype wire

/* tb/dtpt_timer_test.sv */
// self-checking bench for the down timer
`timescale 1ns/1ns
`default_nettype none
module dtpt_timer_test
   import dtpt_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [6:0] adr_i = 7'h00;
   logic [3:0] sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic ext_pin;
   dtpt_pin_t pin2;
   dtpt_pin_t pin0;
   logic tone;
   logic irq;
   int mismatches = 0;
   int n_compared = 0;
   always #5 clk_i = ~clk_i;
   dtpt_timer dtpt_timer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ext_count_pin_i(ext_pin), .port_pin_2_o(pin2),
      .port_pin_0_o(pin0), .tone_out_o(tone), .irq_o(irq));
   dtpt_ext_src dtpt_ext_src_i (.clk_i(clk_i), .pin_o(ext_pin));
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // classic cycle; the wait on ack is bounded
   task automatic wb(input logic w, input logic [6:0] a,
      input logic [7:0] d, output logic [31:0] r);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         mismatches++;
         print_verdict;
      end
   endtask : wb
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, r);
      chk(r, e);
   endtask : rd
   task automatic cnt_is(input logic [9:0] e);
      logic [31:0] r;
      wb(1'b0, 7'h00, 8'h00, r);
      chk(r, {24'h0, e[7:0]});
      wb(1'b0, 7'h40, 8'h00, r);
      chk(r & 32'h30, {26'h0, e[9:8], 4'h0});
   endtask : cnt_is
   task automatic pulses(input int n);
      repeat (n) begin
         dtpt_ext_src_i.edge_to(1'b1);
         dtpt_ext_src_i.edge_to(1'b0);
      end
   endtask : pulses
   task automatic settle;
      repeat (3) @(posedge clk_i);
   endtask : settle
   ////////////////////////////////////////
   task automatic t_reset;
      rd(7'h08, 32'h3f);
      rd(7'h10, 32'hff);
      wr(7'h10, 8'h00);
      rd(7'h10, 32'hff);
      rd(7'h7c, 32'h0);
      cnt_is(10'h000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_count;
      wr(7'h40, 8'h10);
      wr(7'h00, 8'h02);
      cnt_is(10'h102);
      wr(7'h04, 8'h01);
      dtpt_ext_src_i.edge_to(1'b1);
      cnt_is(10'h102);
      pulses(3);
      cnt_is(10'h0ff);
      wr(7'h04, 8'h00);
      pulses(2);
      cnt_is(10'h0ff);
      wr(7'h08, 8'h28);
      wr(7'h04, 8'h01);
      dtpt_ext_src_i.edge_to(1'b1);
      cnt_is(10'h0fe);
      dtpt_ext_src_i.edge_to(1'b0);
      cnt_is(10'h0fe);
      $display("count test done");
   endtask : t_count
   task automatic t_wrap;
      wr(7'h04, 8'h00);
      wr(7'h08, 8'h38);
      wr(7'h40, 8'h00);
      wr(7'h00, 8'h01);
      wr(7'h44, 8'h07);
      wr(7'h04, 8'h01);
      pulses(2);
      cnt_is(10'h3ff);
      rd(7'h44, 32'h07);
      chk({31'h0, irq}, 32'h1);
      wr(7'h44, 8'h02);
      settle;
      chk({31'h0, irq}, 32'h0);
      rd(7'h44, 32'h03);
      wr(7'h44, 8'h01);
      rd(7'h44, 32'h00);
      $display("wrap test done");
   endtask : t_wrap
   task automatic t_modes;
      wr(7'h04, 8'h00);
      wr(7'h00, 8'h02);
      wr(7'h04, 8'h03);
      pulses(3);
      cnt_is(10'h002);
      wr(7'h04, 8'h00);
      wr(7'h00, 8'h01);
      wr(7'h04, 8'h05);
      pulses(3);
      cnt_is(10'h000);
      rd(7'h04, 32'h04);
      wr(7'h08, 8'h39);
      wr(7'h08, 8'h31);
      wr(7'h00, 8'h10);
      wr(7'h04, 8'h01);
      pulses(8);
      cnt_is(10'h00e);
      $display("mode test done");
   endtask : t_modes
   task automatic t_out;
      wr(7'h04, 8'h00);
      wr(7'h08, 8'h38);
      wr(7'h14, 8'h88);
      settle;
      chk({31'h0, tone}, 32'h0);
      wr(7'h04, 8'h01);
      pulses(1);
      settle;
      chk({31'h0, tone}, 32'h1);
      wr(7'h04, 8'h00);
      wr(7'h14, 8'h08);
      settle;
      chk({31'h0, tone}, 32'h0);
      wr(7'h40, 8'h0f);
      wr(7'h0c, 8'hff);
      wr(7'h04, 8'h80);
      settle;
      chk({30'h0, pin2}, 32'h3);
      wr(7'h04, 8'hc0);
      settle;
      chk({30'h0, pin2}, 32'h1);
      wr(7'h40, 8'h03);
      wr(7'h30, 8'h00);
      wr(7'h28, 8'h80);
      settle;
      chk({30'h0, pin0}, 32'h1);
      wr(7'h28, 8'hc0);
      settle;
      chk({30'h0, pin0}, 32'h3);
      rd(7'h0c, 32'h0);
      $display("output test done");
   endtask : t_out
   task automatic t_src;
      logic a;
      logic c;
      wr(7'h04, 8'h00);
      wr(7'h08, 8'h28);
      wr(7'h28, 8'h08);
      wr(7'h00, 8'h05);
      wr(7'h04, 8'h05);
      repeat (20) @(posedge clk_i);
      cnt_is(10'h000);
      rd(7'h04, 32'h04);
      wr(7'h14, 8'h80);
      settle;
      @(negedge clk_i) a = tone;
      repeat (FAST_DIV) @(negedge clk_i);
      c = tone;
      chk({31'h0, a ^ c}, 32'h1);
      wr(7'h14, 8'h81);
      settle;
      @(negedge clk_i) a = tone;
      repeat (2 * FAST_DIV) @(negedge clk_i);
      c = tone;
      chk({31'h0, a ^ c}, 32'h1);
      wr(7'h28, 8'h00);
      wr(7'h08, 8'h08);
      wr(7'h14, 8'h80);
      settle;
      @(negedge clk_i) a = tone;
      repeat (INST_DIV) @(negedge clk_i);
      c = tone;
      chk({31'h0, a ^ c}, 32'h1);
      $display("source test done");
   endtask : t_src
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_count;
      t_wrap;
      t_modes;
      t_out;
      t_src;
      print_verdict;
   end
endmodule : dtpt_timer_test
`default_nettype wire
